// ==== isc_pkg.sv ====
/*
  Constants for the interrupt status collector: register offsets, flag bit
  positions, reset values and the event vector layout.
  Assumes a single 250 MHz clock domain and a plain register port.
*/
// Behaviour
// - Status read returns flags, then clears all
// - Writes to status register are ignored
// - Flags set regardless of mask bits
// - Interrupt asserted while flag and mask both set
// - Bit 23 set while parity error seen
// - Bits 22/21/20 set on bus errors
// - Bit 16 rx status overflow, 10 tx underflow
// - Bit 15 is OR of bits 25..16
// - Bits 14/13/12 phy, wake, software request
// - Bit 11 set on statistics threshold
// - Bit 9 set when tx engine goes idle
// - Bit 8 set after failed tx writeback
package isc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0]  ISC_STATUS_OFS   = 8'h10;   // Read-to-clear status
  localparam logic [7:0]  ISC_MASK_OFS     = 8'h14;   // Enable mask
  localparam logic [7:0]  ISC_CLEAR_OFS    = 8'h18;   // Write-one-to-clear status
  localparam logic [7:0]  ISC_CMD_OFS      = 8'h1c;   // Command, holds software request

  // Flag positions
  localparam int ISC_BIT_TX_RST    = 25;
  localparam int ISC_BIT_RX_RST    = 24;
  localparam int ISC_BIT_PARITY    = 23;
  localparam int ISC_BIT_SYSERR    = 22;
  localparam int ISC_BIT_MABORT    = 21;
  localparam int ISC_BIT_TABORT    = 20;
  localparam int ISC_BIT_RXSOVF    = 16;
  localparam int ISC_BIT_SUMMARY   = 15;
  localparam int ISC_BIT_PHY       = 14;
  localparam int ISC_BIT_WAKE      = 13;
  localparam int ISC_BIT_SWREQ     = 12;
  localparam int ISC_BIT_STATS     = 11;
  localparam int ISC_BIT_TX_FIFO_UNDERFLOW     = 10;
  localparam int ISC_BIT_TX_ENGINE_IDLE    = 9;
  localparam int ISC_BIT_TX_PACKET_FAILED     = 8;
  localparam int ISC_CMD_SWREQ_BIT = 7;   // Software request bit in command register

  // Implemented bits: 25..20, 16..0; 31..26 and 19..17 reserved
  localparam logic [31:0] ISC_VALID_MASK   = 32'h03f1ffff;
  localparam logic [31:0] ISC_HIGH_MASK    = 32'h03f10000;
  localparam logic [31:0] ISC_STATUS_RST   = 32'h03008000;
  localparam logic [31:0] ISC_MASK_RST     = 32'h00000000;
  localparam logic [31:0] ISC_ZERO         = 32'h00000000;

endpackage : isc_pkg

// ==== isc_flag_bank.sv ====
/*
  Sticky flag bank: each bit is set by its event, cleared by a clear vector.
  Assumes events and clears come from the same clock domain.
*/
`timescale 1ns/100ps
module isc_flag_bank #(
  parameter int               WIDTH = 32,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] set_vec,
  input  wire logic [WIDTH-1:0] clr_vec,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_q;  // Sticky storage
  logic [WIDTH-1:0] flags_d;  // Next value

  // A set in the same cycle as a clear wins so no event is lost
  assign flags_d = (flags_q & ~clr_vec) | set_vec;
  assign flags   = flags_q;

  // Flag storage
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_q <= RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  initial begin
    if (WIDTH < 1) $error("isc_flag_bank: WIDTH must be positive");
  end

endmodule : isc_flag_bank

// ==== isc_top.sv ====
/*
  Interrupt status collector: latches engine, FIFO, bus, phy, wake,
  statistics and software events into a read-to-clear status register,
  gates them with an enable mask onto an active-low interrupt line.
  Assumes event inputs are synchronous single-cycle or level strobes from
  logic on clk; the parity level comes from the configuration block.
*/
// Local design decision: strobed register access.
`timescale 1ns/100ps
module isc_top
  import isc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              tx_reset_done,
  input  wire logic              rx_reset_done,
  input  wire logic              parity_error_seen,
  input  wire logic              system_error_signaled,
  input  wire logic              master_abort_received,
  input  wire logic              target_abort_received,
  input  wire logic              rx_status_fifo_overflow,
  input  wire logic              phy_irq,
  input  wire logic              wake_event,
  input  wire logic              statistics_threshold,
  input  wire logic              tx_fifo_underflow,
  input  wire logic              tx_engine_busy,
  input  wire logic              tx_packet_failed,
  input  wire logic [7:0]        low_events,
  output logic                   irq_n
);

  // Status register read has a clearing side effect
  logic [31:0] status;        // Stored flags from the bank
  logic [31:0] status_view;   // Flags with summary bit applied
  logic [31:0] ev_set;        // Events setting flags this cycle
  logic [31:0] ev_clr;        // Clears from read or clear register
  logic [31:0] mask_q;        // Enable mask
  logic [31:0] mask_d;
  logic        swreq_q;       // Software request command bit
  logic        swreq_d;
  logic        busy_q;        // Previous tx engine busy level
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        irq_n_q;
  logic        irq_n_d;

  // Address decode
  wire sel_status = (reg_addr == ADDR_W'(ISC_STATUS_OFS));
  wire sel_mask   = (reg_addr == ADDR_W'(ISC_MASK_OFS));
  wire sel_clear  = (reg_addr == ADDR_W'(ISC_CLEAR_OFS));
  wire sel_cmd    = (reg_addr == ADDR_W'(ISC_CMD_OFS));

  // Tx engine idle edge: busy last cycle, not busy now
  wire tx_idle_edge = busy_q & ~tx_engine_busy;

  // Software request rising edge of the command bit
  wire sw_set = sel_cmd & reg_wr & reg_wdata[ISC_CMD_SWREQ_BIT] & ~swreq_q;

  // Event vector; mask is not consulted here
  always_comb begin
    ev_set                  = ISC_ZERO;
    ev_set[ISC_BIT_TX_RST]  = tx_reset_done;
    ev_set[ISC_BIT_RX_RST]  = rx_reset_done;
    ev_set[ISC_BIT_PARITY]  = parity_error_seen;
    ev_set[ISC_BIT_SYSERR]  = system_error_signaled;
    ev_set[ISC_BIT_MABORT]  = master_abort_received;
    ev_set[ISC_BIT_TABORT]  = target_abort_received;
    ev_set[ISC_BIT_RXSOVF]  = rx_status_fifo_overflow;
    ev_set[ISC_BIT_PHY]     = phy_irq;
    ev_set[ISC_BIT_WAKE]    = wake_event;
    ev_set[ISC_BIT_SWREQ]   = sw_set;
    ev_set[ISC_BIT_STATS]   = statistics_threshold;
    ev_set[ISC_BIT_TX_FIFO_UNDERFLOW]   = tx_fifo_underflow;
    ev_set[ISC_BIT_TX_ENGINE_IDLE]  = tx_idle_edge;
    // Caller pulses this only after the failed descriptor is written back
    ev_set[ISC_BIT_TX_PACKET_FAILED]   = tx_packet_failed;
    ev_set[7:0]             = low_events;
    ev_set                  = ev_set & ISC_VALID_MASK;
  end

  // Read of status clears all flags; writes there do nothing
  assign ev_clr = (sel_status & reg_rd) ? ISC_VALID_MASK :
                  (sel_clear & reg_wr) ? reg_wdata : ISC_ZERO;

  isc_flag_bank #(
    .WIDTH (32),
    .RST   (ISC_STATUS_RST)
  ) u_flags (
    .clk     (clk),
    .srst    (srst),
    .set_vec (ev_set),
    .clr_vec (ev_clr),
    .flags   (status)
  );

  // Summary bit follows the high flags combinationally
  always_comb begin
    status_view                  = status & ISC_VALID_MASK;
    status_view[ISC_BIT_SUMMARY] = |(status & ISC_HIGH_MASK);
  end

  // Mask register is plain read/write, reserved bits forced low
  assign mask_d  = (sel_mask & reg_wr) ? (reg_wdata & ISC_VALID_MASK) : mask_q;
  // Command bit stays as written; only its rising edge raises a flag
  assign swreq_d = (sel_cmd & reg_wr) ? reg_wdata[ISC_CMD_SWREQ_BIT] : swreq_q;

  // Read mux; unmapped addresses read zero
  assign rdata_d = ~reg_rd    ? ISC_ZERO :
                   sel_status ? status_view :
                   sel_mask   ? mask_q :
                   sel_cmd    ? {24'h000000, swreq_q, 7'h00} :
                   ISC_ZERO;

  // Interrupt uses the next flag state so it drops with the clearing read
  logic [31:0] next_view;
  always_comb begin
    next_view                  = ((status & ~ev_clr) | ev_set) & ISC_VALID_MASK;
    next_view[ISC_BIT_SUMMARY] = |(next_view & ISC_HIGH_MASK);
  end
  assign irq_n_d = ~|(next_view & mask_d & ISC_VALID_MASK);

  // Control and output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q    <= ISC_MASK_RST;
      swreq_q   <= 1'b0;
      busy_q    <= 1'b0;
      rdata_q   <= ISC_ZERO;
      irq_n_q   <= 1'b1;
    end else begin
      mask_q    <= mask_d;
      swreq_q   <= swreq_d;
      busy_q    <= tx_engine_busy;
      rdata_q   <= rdata_d;
      irq_n_q   <= irq_n_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_n     = irq_n_q;

  initial begin
    if (ADDR_W < 5) $error("isc_top: ADDR_W too small for the register map");
  end

endmodule : isc_top

// ==== isc_host_model.sv ====
/* Host model: issues single-cycle register writes and reads.
   Assumes each task is entered at a rising clock edge. */
`timescale 1ns/100ps
module isc_host_model (
  input  wire logic        clk,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  // Quiet bus at time zero
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;

  // Write: one strobe cycle, then scramble the released lines
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    @(posedge clk);
  endtask : wr

  // Read: data stands only in the cycle after the strobe, so it is taken
  // at the rising edge that closes that cycle, before it falls back to zero
  task rd(input logic [7:0] a, output logic [31:0] d);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : isc_host_model

// ==== isc_monitor.sv ====
/* Port checker for the status collector.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module isc_monitor
  import isc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              parity_error_seen,
  input wire logic              system_error_signaled,
  input wire logic              rx_status_fifo_overflow,
  input wire logic              phy_irq,
  input wire logic              irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Status register addressed
  wire st_hit = reg_addr == ADDR_W'(ISC_STATUS_OFS);

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == ISC_ZERO)
    else $error("read data outside read slot");
  reserved_zero_a: assert property ((reg_rdata & ~ISC_VALID_MASK) == ISC_ZERO)
    else $error("reserved bit read as one");
  summary_or_a: assert property ($past(reg_rd && st_hit) |-> reg_rdata[15] == |reg_rdata[25:16])
    else $error("summary bit wrong");
  write_ignored_a: assert property (reg_wr && st_hit && !irq_n |-> ##2 !irq_n)
    else $error("status write changed flags");
  parity_flag_a: assert property ($past(parity_error_seen) && reg_rd && st_hit |=> reg_rdata[23])
    else $error("parity flag missing");
  syserr_flag_a: assert property ($past(system_error_signaled) && reg_rd && st_hit |=> reg_rdata[22])
    else $error("system error flag missing");
  rxsovf_flag_a: assert property ($past(rx_status_fifo_overflow) && reg_rd && st_hit |=> reg_rdata[16])
    else $error("overflow flag missing");
  phy_flag_a: assert property ($past(phy_irq) && reg_rd && st_hit |=> reg_rdata[14])
    else $error("phy flag missing");
endmodule : isc_monitor

bind isc_top isc_monitor #(.ADDR_W(ADDR_W)) isc_monitor_inst (.*);

// ==== tb_top.sv ====
/* Self-checking bench for the status collector.
   Assumes the host model drives the register port. */
`timescale 1ns/100ps
module tb_top
  import isc_pkg::*;
;
  logic        clk, srst, busy, irq_n, reg_wr, reg_rd;
  logic [11:0] ev;      // One strobe per flag source except tx idle, software request and low events
  logic [7:0]  low_ev, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, model, mask, got;
  logic [31:0] seed = 32'h00016619;
  int          num_errors, n_compared;
  int          bit_pos [12] = '{25, 24, 23, 22, 21, 20, 16, 14, 13, 11, 10, 8};

  isc_host_model isc_host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  isc_top isc_top_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_reset_done(ev[0]),
    .rx_reset_done(ev[1]), .parity_error_seen(ev[2]), .system_error_signaled(ev[3]),
    .master_abort_received(ev[4]), .target_abort_received(ev[5]), .rx_status_fifo_overflow(ev[6]),
    .phy_irq(ev[7]), .wake_event(ev[8]), .statistics_threshold(ev[9]), .tx_fifo_underflow(ev[10]),
    .tx_engine_busy(busy), .tx_packet_failed(ev[11]), .low_events(low_ev), .irq_n(irq_n));

  // Model value with the summary bit folded in
  function automatic logic [31:0] sum(input logic [31:0] f);
    return f | ((|(f & ISC_HIGH_MASK)) ? 32'h00008000 : ISC_ZERO);
  endfunction : sum
  // Fixed-seed xorshift source
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Read a register and compare
  task rs(input logic [7:0] a, input logic [31:0] e, input string nm);
    isc_host_model_inst.rd(a, got);
    chk(nm, got, e);
  endtask : rs
  task close_out;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cuts a hang well past the expected 154 or so cycles
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    {srst, ev, low_ev, busy} = {1'b1, 21'h0};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("irq_n reset", {31'h0, irq_n}, 32'h1);
    @(posedge clk);
    rs(ISC_STATUS_OFS, ISC_STATUS_RST, "status reset");
    rs(ISC_STATUS_OFS, ISC_ZERO, "status cleared");
    // Pass 0 unmasked, pass 1 random mask with line check
    for (int p = 0; p < 2; p++) begin
      mask = p ? (xs() & ISC_VALID_MASK) : ISC_ZERO;
      isc_host_model_inst.wr(ISC_MASK_OFS, mask);
      foreach (bit_pos[i]) begin
        ev[i] <= 1'b1;
        model = sum(32'h1 << bit_pos[i]);
        @(posedge clk);
        ev[i] <= 1'b0;
        if (p) begin
          repeat (2) @(posedge clk);
          #1 chk("irq_n", {31'h0, irq_n}, {31'h0, (model & mask) == 0});
          @(posedge clk);
        end
        rs(ISC_STATUS_OFS, model, "event flag");
      end
    end
    rs(ISC_MASK_OFS, mask, "mask readback");
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    rs(ISC_STATUS_OFS, 32'h00000200, "tx idle");
    isc_host_model_inst.wr(ISC_CMD_OFS, 32'h00000080);
    rs(ISC_STATUS_OFS, 32'h00001000, "software request");
    // Full mask so the write lands while the line is low
    isc_host_model_inst.wr(ISC_MASK_OFS, ISC_VALID_MASK);
    got = xs() | 32'h1;
    low_ev <= got[7:0];
    model = {24'h0, got[7:0]};
    @(posedge clk);
    low_ev <= 8'h00;
    repeat (2) @(posedge clk);
    isc_host_model_inst.wr(ISC_STATUS_OFS, 32'hffffffff);
    rs(ISC_STATUS_OFS, model, "write ignored");
    ev[0] <= 1'b1;
    @(posedge clk);
    ev[0] <= 1'b0;
    isc_host_model_inst.wr(ISC_CLEAR_OFS, 32'hffffffff);
    rs(ISC_STATUS_OFS, ISC_ZERO, "clear register");
    rs(8'h40, ISC_ZERO, "unmapped read");
    close_out();
  end
endmodule : tb_top
